// ### dual_six_bit_io_port.sv
// Two six-bit general-purpose I/O ports with direction logic, plus pull-up and wake logic on port B only
`default_nettype none
module dual_six_bit_io_port
  import gpio_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_select,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic bit_set_op,
  input wire logic bit_clear_op,
  input wire logic [2:0] bit_index,
  input wire logic direction_load_instruction,
  input wire logic option_load,
  input wire logic status_wake_clear,
  input wire logic [5:0] alt_func_b,
  input wire logic [5:0] alt_func_c,
  input wire logic [5:0] port_b_pin_in,
  input wire logic [5:0] port_c_pin_in,
  output logic [7:0] read_data,
  output logic [5:0] port_b_pin_out,
  output logic [5:0] port_b_pin_oe,
  output logic [5:0] port_c_pin_out,
  output logic [5:0] port_c_pin_oe,
  output logic [5:0] port_b_pullup,
  output logic wake_change_flag
);

  logic [5:0] b_meta, b_sync, c_meta, c_sync, b_prev;
  logic [5:0] b_latch, c_latch, b_dir, c_dir;
  logic [7:0] option_reg;
  logic [7:0] next_read;
  logic [7:0] rmw_value;
  logic rmw_op;
  logic [5:0] wake_arm;
  logic pullup_enable_n, wake_change_enable_n, c5_dir;

  // Apply a set or clear of one bit to a sampled pin image
  function automatic logic [7:0] bit_modify(input logic [7:0] v,
      input logic [2:0] idx, input logic set);
    logic [7:0] r;
    r = v;
    r[idx] = set;
    return r;
  endfunction : bit_modify

  // Pin image as the core sees it: alternate functions read low
  function automatic logic [7:0] port_image(input logic [5:0] pins,
      input logic [5:0] alt);
    return {2'b00, pins & ~alt};
  endfunction : port_image

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      b_meta <= 6'h00;
      b_sync <= 6'h00;
      c_meta <= 6'h00;
      c_sync <= 6'h00;
    end else begin
      b_meta <= port_b_pin_in;
      b_sync <= b_meta;
      c_meta <= port_c_pin_in;
      c_sync <= c_meta;
    end
  end

  assign pullup_enable_n = option_reg[OPT_PULLUP_N_BIT];
  assign wake_change_enable_n = option_reg[OPT_WAKE_N_BIT];
  assign c5_dir = c_dir[C5_BIT] | option_reg[OPT_C5_DIR_BIT];
  assign rmw_op = bit_set_op | bit_clear_op;
  // Wake and pull-up only on inputs of the capable bits
  assign wake_arm = WAKE_PULL_MASK & b_dir;

  // Read data: pins come through the two-flop synchronizer, so they show their value from two cycles before the read strobe
  always_comb begin
    next_read = 8'h00;
    if (reg_select == PORT_B_ADDR) begin
      next_read = port_image(b_sync, alt_func_b);
    end else if (reg_select == PORT_C_ADDR) begin
      next_read = port_image(c_sync, alt_func_c);
    end else if (reg_select == STATUS_ADDR) begin
      next_read[STATUS_WAKE_BIT] = wake_change_flag;
    end
    read_data = read_strobe ? next_read : 8'h00;
    rmw_value = bit_modify(next_read, bit_index, bit_set_op);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      b_latch <= LATCH_RESET;
      c_latch <= LATCH_RESET;
    end else if (write_strobe || rmw_op) begin
      // Latch written at the end of the instruction cycle
      if (reg_select == PORT_B_ADDR) begin
        b_latch <= rmw_op ? rmw_value[5:0] : write_data[5:0];
      end else if (reg_select == PORT_C_ADDR) begin
        c_latch <= rmw_op ? rmw_value[5:0] : write_data[5:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      b_dir <= DIR_RESET;
      c_dir <= DIR_RESET;
    end else if (direction_load_instruction) begin
      if (reg_select == PORT_B_ADDR) begin
        b_dir <= write_data[5:0];
      end else if (reg_select == PORT_C_ADDR) begin
        c_dir <= write_data[5:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      option_reg <= OPTION_RESET;
    end else if (option_load) begin
      option_reg <= write_data;
    end
  end

  // Pad drivers registered so outputs come straight from flip-flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_b_pin_out <= 6'h00;
      port_b_pin_oe <= 6'h00;
      port_c_pin_out <= 6'h00;
      port_c_pin_oe <= 6'h00;
      port_b_pullup <= 6'h00;
    end else begin
      port_b_pin_out <= b_latch;
      port_b_pin_oe <= ~b_dir & ~(6'h01 << INPUT_ONLY_BIT);
      port_c_pin_out <= c_latch;
      port_c_pin_oe <= ~{c5_dir, c_dir[4:0]};
      port_b_pullup <= pullup_enable_n ? 6'h00 : wake_arm;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      b_prev <= 6'h00;
    end else begin
      b_prev <= b_sync;
    end
  end

  // Flag set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_change_flag <= 1'b0;
    end else if (!wake_change_enable_n &&
        |((b_sync ^ b_prev) & wake_arm)) begin
      wake_change_flag <= 1'b1;
    end else if (status_wake_clear) begin
      wake_change_flag <= 1'b0;
    end
  end

  reset_dir_a: assert property (@(posedge sys_clk)
      $rose(rst_b) |-> (b_dir == DIR_RESET && c_dir == DIR_RESET))
    else $error("direction not all inputs after reset");
  input_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !port_b_pin_oe[INPUT_ONLY_BIT])
    else $error("input-only pin driven");
  upper_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_data[7:6] == 2'b00 || reg_select == STATUS_ADDR)
    else $error("unimplemented port bits read nonzero");
  read_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_strobe && reg_select == PORT_B_ADDR |->
      read_data[5:0] == ($past(port_b_pin_in, 2) & ~alt_func_b))
    else $error("port read not from pins");
  dir_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      direction_load_instruction && reg_select == PORT_C_ADDR
      && !write_data[0] |=> ##1 port_c_pin_oe[0])
    else $error("cleared direction bit does not drive");
  dir_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !direction_load_instruction |=> $stable(b_dir) && $stable(c_dir))
    else $error("direction changed without load");
  latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !write_strobe && !rmw_op |=> $stable(b_latch) && $stable(c_latch))
    else $error("latch changed without write");
  rmw_write_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      bit_set_op && reg_select == PORT_B_ADDR && bit_index < 3'd6 |=>
      b_latch[$past(bit_index)])
    else $error("bit set did not land");
  pullup_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      option_reg[OPT_PULLUP_N_BIT] |=> port_b_pullup == 6'h00)
    else $error("pull-up on while disabled");
  c5_override_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      option_reg[OPT_C5_DIR_BIT] |=> !port_c_pin_oe[C5_BIT])
    else $error("option did not float port C bit 5");

  // Pad outputs track the latches and direction bits one cycle later

  out_b_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=>
      port_b_pin_out == $past(b_latch))
    else $error("port B pad value does not follow latch");

  out_c_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=>
      port_c_pin_out == $past(c_latch))
    else $error("port C pad value does not follow latch");

  oe_b_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |=>
      port_b_pin_oe == (~$past(b_dir) & ~(6'h01 << INPUT_ONLY_BIT)))
    else $error("port B enable does not follow direction");

  dir_b_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      direction_load_instruction && reg_select == PORT_B_ADDR |=>
      b_dir == $past(write_data[5:0]))
    else $error("port B direction not loaded");

  write_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_strobe && !rmw_op && reg_select == PORT_C_ADDR |=>
      c_latch == $past(write_data[5:0]))
    else $error("port C write did not land");

  rmw_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      bit_clear_op && !bit_set_op && reg_select == PORT_B_ADDR
      && bit_index < 3'd6 |=> !b_latch[$past(bit_index)])
    else $error("bit clear did not land");

  // Read path

  c_read_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_strobe && reg_select == PORT_C_ADDR |->
      read_data[5:0] == ($past(port_c_pin_in, 2) & ~alt_func_c))
    else $error("port C read not from pins");

  status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_strobe && reg_select == STATUS_ADDR |->
      read_data == {wake_change_flag, 7'h00})
    else $error("status read wrong");

  no_dir_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_strobe && reg_select != STATUS_ADDR && reg_select != PORT_B_ADDR
      && reg_select != PORT_C_ADDR |-> read_data == 8'h00)
    else $error("unmapped read not zero");

  idle_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !read_strobe |->
      read_data == 8'h00)
    else $error("read data without strobe");

  // Pull-up and wake on change

  pull_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      1'b1 |->
      (port_b_pullup & ~WAKE_PULL_MASK) == 6'h00)
    else $error("pull-up on an incapable bit");

  pull_on_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !option_reg[OPT_PULLUP_N_BIT] |=>
      port_b_pullup == ($past(b_dir) & WAKE_PULL_MASK))
    else $error("pull-up not on inputs of capable bits");

  wake_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !wake_change_enable_n && |((b_sync ^ b_prev) & wake_arm) |=>
      wake_change_flag)
    else $error("pin change did not set wake flag");

  wake_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wake_change_flag && !status_wake_clear |=>
      wake_change_flag)
    else $error("wake flag lost without clear");

  wake_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wake_change_enable_n && !wake_change_flag |=>
      !wake_change_flag)
    else $error("wake flag set while disabled");

  cov_rmw_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
      bit_clear_op && reg_select == PORT_B_ADDR);
  cov_wake_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(wake_change_flag));
  cov_drive_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
      port_b_pin_oe != 6'h00);
  cov_c_read_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
      read_strobe && reg_select == PORT_C_ADDR);
  cov_override_c: cover property (@(posedge sys_clk) disable iff (!rst_b)
      option_reg[OPT_C5_DIR_BIT] && !c_dir[C5_BIT]);

endmodule : dual_six_bit_io_port
`default_nettype wire

// ### gpio_port_pkg.sv
// Package with addresses, field positions and reset values of the I/O ports
`default_nettype none
package gpio_port_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam logic [7:0] PORT_B_ADDR = 8'h06;
  localparam logic [7:0] PORT_C_ADDR = 8'h07;
  localparam int PORT_W = 6;
  localparam logic [5:0] DIR_RESET = 6'h3f;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam int OPT_WAKE_N_BIT = 7;
  localparam int OPT_PULLUP_N_BIT = 6;
  localparam int OPT_C5_DIR_BIT = 5;
  localparam int STATUS_WAKE_BIT = 7;
  localparam int INPUT_ONLY_BIT = 3;
  localparam int C5_BIT = 5;
  localparam logic [5:0] WAKE_PULL_MASK = 6'h1b;
  localparam logic [5:0] LATCH_RESET = 6'h00;
endpackage : gpio_port_pkg
`default_nettype wire

// ### pin_world.sv
// Behavioural model of the circuits wired to one six-bit port
`default_nettype none
module pin_world (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pull_en,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] drift;
  initial drift = 6'h15;
  // A floating pin without pull-up wanders every cycle
  always @(posedge clk) drift <= ~drift;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pull_en[i] ? 1'b1 : drift[i];
    end
  end
endmodule : pin_world
`default_nettype wire

// ### test_dual_six_bit_io_port.sv
// Self-checking bench for the dual six-bit I/O port
`default_nettype none
module test_dual_six_bit_io_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_b = 0, ws = 0, rs = 0, bs = 0, bc = 0, dl = 0;
  logic ol = 0, wc = 0;
  logic [7:0] sel = 0, wd = 0, rdat;
  logic [2:0] idx = 0;
  logic [5:0] alt_b = 0, alt_c = 0, in_b, in_c, out_b, oe_b, out_c, oe_c;
  logic [5:0] pu, ext_b = 0, ext_c = 0, en = 6'h3f;
  logic flag;
  int num_errors = 0, check_count = 0;
  logic [5:0] rows [4][6] = '{'{6'h3f, 6'h3f, 6'h00, 6'h00, 6'h3f, 6'h3f},
    '{6'h15, 6'h2a, 6'h00, 6'h00, 6'h15, 6'h2a},
    '{6'h3f, 6'h3f, 6'h21, 6'h0c, 6'h1e, 6'h33},
    '{6'h2a, 6'h15, 6'h08, 6'h01, 6'h22, 6'h14}};
  dual_six_bit_io_port dual_six_bit_io_port_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .reg_select(sel), .write_data(wd), .write_strobe(ws),
    .read_strobe(rs), .bit_set_op(bs), .bit_clear_op(bc), .bit_index(idx),
    .direction_load_instruction(dl), .option_load(ol),
    .status_wake_clear(wc), .alt_func_b(alt_b), .alt_func_c(alt_c),
    .port_b_pin_in(in_b), .port_c_pin_in(in_c), .read_data(rdat),
    .port_b_pin_out(out_b), .port_b_pin_oe(oe_b), .port_c_pin_out(out_c),
    .port_c_pin_oe(oe_c), .port_b_pullup(pu), .wake_change_flag(flag));
  pin_world pin_world_b_i (.clk(sys_clk), .pin_out(out_b), .pin_oe(oe_b),
    .pull_en(pu), .ext_en(en), .ext_val(ext_b), .pin_in(in_b));
  pin_world pin_world_c_i (.clk(sys_clk), .pin_out(out_c), .pin_oe(oe_c),
    .pull_en(6'h00), .ext_en(en), .ext_val(ext_c), .pin_in(in_c));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  // Kinds: 0 write, 1 bit set, 2 bit clear, 3 direction, 4 option, 5 clear
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] i);
    @(negedge sys_clk);
    sel = a;
    wd = d;
    idx = i;
    case (k)
      0: ws = 1;
      1: bs = 1;
      2: bc = 1;
      3: dl = 1;
      4: ol = 1;
      default: wc = 1;
    endcase
    @(negedge sys_clk);
    {ws, bs, bc, dl, ol, wc} = 6'h00;
    repeat (4) @(negedge sys_clk);
  endtask : op
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    sel = a;
    rs = 1;
    #1 chk(rdat, exp);
    @(negedge sys_clk);
    rs = 0;
  endtask : rd
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    #200us;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    chk({oe_b, oe_c}, 8'h00);
    chk({pu, 1'b0, flag}, 8'h00);
    rst_b = 1;
    foreach (rows[r]) begin
      {ext_b, ext_c, alt_b, alt_c} = {rows[r][0], rows[r][1], rows[r][2],
                                      rows[r][3]};
      repeat (3) @(negedge sys_clk);
      rd(8'h06, {2'b00, rows[r][4]});
      rd(8'h07, {2'b00, rows[r][5]});
    end
    {alt_b, alt_c, ext_b} = {6'h00, 6'h00, 6'h15};
    op(1, 8'h06, 8'h00, 3'd1);
    op(2, 8'h06, 8'h00, 3'd2);
    op(3, 8'h06, 8'h00, 3'd0);
    chk(oe_b, 6'h37);
    chk(out_b & 6'h37, 6'h11);
    op(0, 8'h06, 8'h2a, 3'd0);
    rd(8'h06, 8'h22);
    ext_b = 6'h00;
    rd(8'h06, 8'h22);
    op(3, 8'h06, 8'h3c, 3'd0);
    op(4, 8'h00, 8'h3f, 3'd0);
    chk(pu, 6'h18);
    op(0, 8'h07, 8'h3f, 3'd0);
    op(3, 8'h07, 8'h00, 3'd0);
    chk(oe_c, 6'h1f);
    op(4, 8'h00, 8'hdf, 3'd0);
    chk({oe_c, pu}, 12'hfc0);
    op(4, 8'h00, 8'h7f, 3'd0);
    ext_b = 6'h02;
    op(3, 8'h06, 8'h3f, 3'd0);
    chk(flag, 1'b0);
    ext_b = 6'h03;
    repeat (6) @(negedge sys_clk);
    chk(flag, 1'b1);
    rd(8'h03, 8'h80);
    op(5, 8'h03, 8'h00, 3'd0);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h00);
    final_report();
  end
endmodule : test_dual_six_bit_io_port
`default_nettype wire
